/* File: hw/rhb_pkg.sv */
// Package: register map, reset values, thresholds and states of the mode controller
package rhb_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TON_MIN = 8'h04;
   localparam logic [7:0] OFS_TON_MAX = 8'h08;
   localparam logic [7:0] OFS_TNO_MIN = 8'h0c;
   localparam logic [7:0] OFS_TNO_MAX = 8'h10;
   localparam logic [7:0] OFS_LP_LEVEL = 8'h14;
   localparam logic [7:0] OFS_MIN_SWING = 8'h18;
   localparam logic [7:0] OFS_LP_BOOST = 8'h1c;
   localparam logic [7:0] OFS_BURST_TGT = 8'h20;
   localparam logic [7:0] OFS_ENTRY_DLY = 8'h24;
   localparam logic [7:0] OFS_EXIT_DLY = 8'h28;
   localparam logic [7:0] OFS_LP_HOLD = 8'h2c;
   localparam logic [7:0] OFS_STOP_THR = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;
   // Control field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DLY_BIT = 1;
   // Reset values of the settings
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [15:0] RST_TON_MIN = 16'h0028;
   localparam logic [15:0] RST_TON_MAX = 16'h03e8;
   localparam logic [15:0] RST_TNO_MIN = 16'h0008;
   localparam logic [15:0] RST_TNO_MAX = 16'h0050;
   localparam logic [7:0] RST_LP_LEVEL = 8'h40;
   localparam logic [7:0] RST_MIN_SWING = 8'h10;
   localparam logic [7:0] RST_LP_BOOST = 8'h20;
   localparam logic [15:0] RST_BURST_TGT = 16'h1000;
   localparam logic [15:0] RST_ENTRY_DLY = 16'h0800;
   localparam logic [15:0] RST_EXIT_DLY = 16'h0800;
   localparam logic [15:0] RST_LP_HOLD = 16'h0100;
   localparam logic [7:0] RST_STOP_THR = 8'h96;
   // Optocurrent levels in microamps
   localparam logic [7:0] START_BURST_UA = 8'h64;
   localparam logic [7:0] OPTO_TARGET_UA = 8'h50;
   localparam logic [7:0] TRANSIENT_UA = 8'h28;
   // Extra swing added while a load step is seen
   localparam logic [7:0] TRANSIENT_WIDEN = 8'h10;
   // Last prescaler count before an offset step (one step per 256 clocks), keeps the offset loop slow
   localparam logic [7:0] OFFS_STEP_CYC = 8'hff;
   typedef enum logic [2:0] {
      RHB_IDLE = 3'b000,
      RHB_LS_ON = 3'b001,
      RHB_LS_DT = 3'b010,
      RHB_HS_ON = 3'b011,
      RHB_HS_DT = 3'b100,
      RHB_HOLD = 3'b101,
      RHB_BOFF = 3'b110
   } rhb_gate_type;
   typedef enum logic [1:0] {
      RHB_HP = 2'b00,
      RHB_LP = 2'b01,
      RHB_BURST = 2'b10
   } rhb_mode_type;
endpackage

/* File: hw/rhb_sync.sv */
// Two-stage synchroniser for comparator and measurement inputs
`timescale 1ns/1ps
module rhb_sync #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } rhb_sync_type;
   rhb_sync_type s_reg;
   rhb_sync_type s_next;
   // First stage feeds only the second stage
   always_comb begin
      s_next.first = async_in;
      s_next.second = s_reg.first;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign sync_out = s_reg.second;
endmodule

/* File: hw/rhb_mode_ctrl.sv */
// Resonant half-bridge mode controller with APB settings
`timescale 1ns/1ps
module rhb_mode_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cap_below_low,
   input wire logic cap_above_high,
   input wire logic ocp_detect,
   input wire logic cap_mode_near,
   input wire logic hb_peak,
   input wire logic ires_le_zero,
   input wire logic ires_ge_zero,
   input wire logic out_rising,
   input wire logic [7:0] power_demand,
   input wire logic [7:0] feedback_ua,
   output logic low_side_gate,
   output logic high_side_gate,
   output logic [7:0] cap_swing_level,
   output logic [1:0] mode_state
);
   typedef struct packed {
      rhb_pkg::rhb_gate_type gate;
      rhb_pkg::rhb_mode_type mode;
      logic [15:0] tmr;
      logic [1:0] hc;
      logic [7:0] burst_cnt;
      logic [7:0] burst_done;
      logic [15:0] bper;
      logic [15:0] sw_time;
      logic [15:0] entry_tmr;
      logic [7:0] offs;
      logic [7:0] presc;
      logic [7:0] swing;
      logic ls;
      logic hs;
      logic [31:0] rdata;
      logic [1:0] ctrl;
      logic [15:0] ton_min;
      logic [15:0] ton_max;
      logic [15:0] tno_min;
      logic [15:0] tno_max;
      logic [7:0] lp_level;
      logic [7:0] min_swing;
      logic [7:0] lp_boost;
      logic [15:0] burst_tgt;
      logic [15:0] entry_dly;
      logic [15:0] exit_dly;
      logic [15:0] lp_hold;
      logic [7:0] stop_thr;
   } rhb_state_type;

   localparam int NSYNC = 24;
   rhb_state_type s_reg;
   rhb_state_type s_next;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_s;
   logic c_low, c_high, ocp, cnear, peak, i_le, i_ge, rising;
   logic [7:0] demand;
   logic [7:0] fb;
   logic [8:0] base_sum;
   logic [7:0] base_sw;
   logic [8:0] lp_sum;
   logic [7:0] lp_sw;
   logic [8:0] tr_sum;
   logic transient;
   logic low_end, high_end, ls_adv, hs_adv;
   logic setup_rd, access_wr, addr_ok;

   // All comparator and measurement pins are outside the clock domain, so every one is synchronised
   assign pin_raw = {cap_below_low, cap_above_high, ocp_detect,
                     cap_mode_near, hb_peak, ires_le_zero, ires_ge_zero,
                     out_rising, power_demand, feedback_ua};
   rhb_sync #(.W(NSYNC)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );
   assign {c_low, c_high, ocp, cnear, peak, i_le, i_ge, rising,
           demand, fb} = pin_s;

   // Swing targets; demand plus slow offset, saturating at full scale
   always_comb begin
      base_sum = {1'b0, demand} + {1'b0, s_reg.offs};
      base_sw = base_sum[8] ? 8'hff : base_sum[7:0];
      lp_sum = {1'b0, base_sw} + {1'b0, s_reg.lp_boost};
      lp_sw = lp_sum[8] ? 8'hff : lp_sum[7:0];
      transient = fb < rhb_pkg::TRANSIENT_UA;
      tr_sum = 9'h000;
      low_end = 1'b0;
      high_end = 1'b0;
      ls_adv = 1'b0;
      hs_adv = 1'b0;
      // On-state end conditions, guarded by minimum on-time
      if (s_reg.tmr >= s_reg.ton_min) begin
         low_end = c_low | ocp | cnear | (s_reg.tmr >= s_reg.ton_max);
         high_end = c_high | ocp | cnear | (s_reg.tmr >= s_reg.ton_max);
      end
      // Dead-time exit: peak after min time, or max time, current sign ok
      if (s_reg.tmr >= s_reg.tno_min) begin
         ls_adv = i_le & (peak | (s_reg.tmr >= s_reg.tno_max));
         hs_adv = i_ge & (peak | (s_reg.tmr >= s_reg.tno_max));
      end
      if (transient) begin
         tr_sum = {1'b0, lp_sw} + {1'b0, rhb_pkg::TRANSIENT_WIDEN};
      end
   end

   assign setup_rd = psel & ~penable & ~pwrite;
   assign access_wr = psel & penable & pwrite;
   assign addr_ok = (paddr <= rhb_pkg::OFS_STATUS) && (paddr[1:0] == 2'b00);

   // Next-state logic for gates, modes, burst bookkeeping and registers
   always_comb begin
      s_next = s_reg;
      s_next.tmr = s_reg.tmr + 16'h0001;
      s_next.presc = s_reg.presc + 8'h01;
      // Slow offset loop toward the optocurrent target
      if (s_reg.presc == rhb_pkg::OFFS_STEP_CYC) begin
         s_next.presc = 8'h00;
         if (fb < rhb_pkg::OPTO_TARGET_UA && s_reg.offs != 8'hff) begin
            s_next.offs = s_reg.offs + 8'h01;
         end else if (fb > rhb_pkg::OPTO_TARGET_UA && s_reg.offs != 8'h00) begin
            s_next.offs = s_reg.offs - 8'h01;
         end
      end
      // Swing level: boosted in low-power modes, floored at minimum
      if (s_reg.mode == rhb_pkg::RHB_HP) begin
         s_next.swing = base_sw;
      end else if (lp_sw < s_reg.min_swing) begin
         s_next.swing = s_reg.min_swing;
      end else begin
         s_next.swing = lp_sw;
      end
      if (transient) begin
         s_next.swing = tr_sum[8] ? 8'hff : tr_sum[7:0];
      end
      // Burst period and switching time counters saturate
      if (s_reg.bper != 16'hffff) begin
         s_next.bper = s_reg.bper + 16'h0001;
      end
      if (s_reg.gate == rhb_pkg::RHB_BOFF) begin
         s_next.sw_time = 16'h0000;
      end else if (s_reg.sw_time != 16'hffff) begin
         s_next.sw_time = s_reg.sw_time + 16'h0001;
      end
      // Mode transitions
      case (s_reg.mode)
         rhb_pkg::RHB_HP: begin
            s_next.entry_tmr = 16'h0000;
            if (demand < s_reg.lp_level) begin
               s_next.mode = rhb_pkg::RHB_LP;
            end
         end
         rhb_pkg::RHB_LP: begin
            if (demand >= s_reg.lp_level) begin
               s_next.mode = rhb_pkg::RHB_HP;
            end else if (lp_sw <= s_reg.min_swing) begin
               // Delay keeps short dips from causing audible bursts
               if (!s_reg.ctrl[rhb_pkg::CTRL_DLY_BIT] || rising ||
                   s_reg.entry_tmr >= s_reg.entry_dly) begin
                  s_next.mode = rhb_pkg::RHB_BURST;
                  s_next.burst_cnt = 8'h01;
                  s_next.burst_done = 8'h00;
                  s_next.bper = 16'h0000;
               end else begin
                  s_next.entry_tmr = s_reg.entry_tmr + 16'h0001;
               end
            end else begin
               s_next.entry_tmr = 16'h0000;
            end
         end
         default: begin
            if (s_reg.sw_time > s_reg.exit_dly &&
                lp_sw > s_reg.min_swing) begin
               s_next.mode = rhb_pkg::RHB_LP;
               s_next.entry_tmr = 16'h0000;
            end
         end
      endcase
      // Gate sequencer
      case (s_reg.gate)
         rhb_pkg::RHB_IDLE: begin
            s_next.ls = 1'b0;
            s_next.hs = 1'b0;
            s_next.hc = 2'b00;
            if (s_reg.ctrl[rhb_pkg::CTRL_EN_BIT]) begin
               s_next.gate = rhb_pkg::RHB_LS_ON;
               s_next.ls = 1'b1;
               s_next.tmr = 16'h0000;
            end
         end
         rhb_pkg::RHB_LS_ON: begin
            if (low_end) begin
               s_next.ls = 1'b0;
               s_next.tmr = 16'h0000;
               // Third half-cycle in low-power modes ends in a hold
               if (s_reg.mode != rhb_pkg::RHB_HP && s_reg.hc == 2'b10) begin
                  s_next.gate = rhb_pkg::RHB_HOLD;
                  s_next.hc = 2'b00;
                  if (s_reg.mode == rhb_pkg::RHB_BURST) begin
                     s_next.burst_done = s_reg.burst_done + 8'h01;
                  end
               end else begin
                  s_next.gate = rhb_pkg::RHB_LS_DT;
                  s_next.hc = s_reg.hc + 2'b01;
               end
            end
         end
         rhb_pkg::RHB_LS_DT: begin
            if (ls_adv) begin
               s_next.gate = rhb_pkg::RHB_HS_ON;
               s_next.hs = 1'b1;
               s_next.tmr = 16'h0000;
            end
         end
         rhb_pkg::RHB_HS_ON: begin
            if (high_end) begin
               s_next.gate = rhb_pkg::RHB_HS_DT;
               s_next.hs = 1'b0;
               s_next.tmr = 16'h0000;
               s_next.hc = s_reg.hc + 2'b01;
            end
         end
         rhb_pkg::RHB_HS_DT: begin
            if (hs_adv) begin
               s_next.gate = rhb_pkg::RHB_LS_ON;
               s_next.ls = 1'b1;
               s_next.tmr = 16'h0000;
            end
         end
         rhb_pkg::RHB_HOLD: begin
            // Burst ends once burst_done reaches burst_cnt or on overshoot
            if (s_reg.mode == rhb_pkg::RHB_BURST &&
                (s_reg.burst_done >= s_reg.burst_cnt ||
                 fb > s_reg.stop_thr)) begin
               s_next.gate = rhb_pkg::RHB_BOFF;
            end else if (s_reg.tmr >= s_reg.tno_min &&
                         (s_reg.tmr >= s_reg.lp_hold ||
                          s_reg.mode == rhb_pkg::RHB_HP)) begin
               s_next.gate = rhb_pkg::RHB_LS_ON;
               s_next.ls = 1'b1;
               s_next.tmr = 16'h0000;
            end
         end
         rhb_pkg::RHB_BOFF: begin
            // Long both-off hold; restart on low optocurrent or load step
            if (s_reg.tmr >= s_reg.tno_min &&
                (s_reg.mode != rhb_pkg::RHB_BURST || transient ||
                 fb < rhb_pkg::START_BURST_UA)) begin
               s_next.gate = rhb_pkg::RHB_LS_ON;
               s_next.ls = 1'b1;
               s_next.tmr = 16'h0000;
               s_next.burst_done = 8'h00;
               s_next.bper = 16'h0000;
               if (s_reg.bper < s_reg.burst_tgt &&
                   s_reg.burst_cnt != 8'hff) begin
                  s_next.burst_cnt = s_reg.burst_cnt + 8'h01;
               end
            end
         end
         default: begin
            s_next.gate = rhb_pkg::RHB_IDLE;
         end
      endcase
      // Disable drops both gates at once
      if (!s_reg.ctrl[rhb_pkg::CTRL_EN_BIT]) begin
         s_next.gate = rhb_pkg::RHB_IDLE;
         s_next.ls = 1'b0;
         s_next.hs = 1'b0;
      end
      // APB read data captured in setup so it is stable in access
      if (setup_rd) begin
         s_next.rdata = 32'h0000_0000;
         if (paddr == rhb_pkg::OFS_CTRL) begin
            s_next.rdata = {30'h0, s_reg.ctrl};
         end else if (paddr == rhb_pkg::OFS_TON_MIN) begin
            s_next.rdata = {16'h0, s_reg.ton_min};
         end else if (paddr == rhb_pkg::OFS_TON_MAX) begin
            s_next.rdata = {16'h0, s_reg.ton_max};
         end else if (paddr == rhb_pkg::OFS_TNO_MIN) begin
            s_next.rdata = {16'h0, s_reg.tno_min};
         end else if (paddr == rhb_pkg::OFS_TNO_MAX) begin
            s_next.rdata = {16'h0, s_reg.tno_max};
         end else if (paddr == rhb_pkg::OFS_LP_LEVEL) begin
            s_next.rdata = {24'h0, s_reg.lp_level};
         end else if (paddr == rhb_pkg::OFS_MIN_SWING) begin
            s_next.rdata = {24'h0, s_reg.min_swing};
         end else if (paddr == rhb_pkg::OFS_LP_BOOST) begin
            s_next.rdata = {24'h0, s_reg.lp_boost};
         end else if (paddr == rhb_pkg::OFS_BURST_TGT) begin
            s_next.rdata = {16'h0, s_reg.burst_tgt};
         end else if (paddr == rhb_pkg::OFS_ENTRY_DLY) begin
            s_next.rdata = {16'h0, s_reg.entry_dly};
         end else if (paddr == rhb_pkg::OFS_EXIT_DLY) begin
            s_next.rdata = {16'h0, s_reg.exit_dly};
         end else if (paddr == rhb_pkg::OFS_LP_HOLD) begin
            s_next.rdata = {16'h0, s_reg.lp_hold};
         end else if (paddr == rhb_pkg::OFS_STOP_THR) begin
            s_next.rdata = {24'h0, s_reg.stop_thr};
         end else if (paddr == rhb_pkg::OFS_STATUS) begin
            s_next.rdata = {3'h0, s_reg.gate, s_reg.mode, s_reg.burst_cnt,
                            s_reg.offs, s_reg.swing};
         end
      end
      // APB writes take effect in the access cycle
      if (access_wr) begin
         if (paddr == rhb_pkg::OFS_CTRL) begin
            s_next.ctrl = pwdata[1:0];
         end else if (paddr == rhb_pkg::OFS_TON_MIN) begin
            s_next.ton_min = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_TON_MAX) begin
            s_next.ton_max = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_TNO_MIN) begin
            s_next.tno_min = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_TNO_MAX) begin
            s_next.tno_max = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_LP_LEVEL) begin
            s_next.lp_level = pwdata[7:0];
         end else if (paddr == rhb_pkg::OFS_MIN_SWING) begin
            s_next.min_swing = pwdata[7:0];
         end else if (paddr == rhb_pkg::OFS_LP_BOOST) begin
            s_next.lp_boost = pwdata[7:0];
         end else if (paddr == rhb_pkg::OFS_BURST_TGT) begin
            s_next.burst_tgt = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_ENTRY_DLY) begin
            s_next.entry_dly = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_EXIT_DLY) begin
            s_next.exit_dly = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_LP_HOLD) begin
            s_next.lp_hold = pwdata[15:0];
         end else if (paddr == rhb_pkg::OFS_STOP_THR) begin
            s_next.stop_thr = pwdata[7:0];
         end
      end
   end

   // Settings come up at their rhb_pkg reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0; // Idle gates and high-power mode are code zero
         s_reg.ctrl <= rhb_pkg::RST_CTRL;
         s_reg.ton_min <= rhb_pkg::RST_TON_MIN;
         s_reg.ton_max <= rhb_pkg::RST_TON_MAX;
         s_reg.tno_min <= rhb_pkg::RST_TNO_MIN;
         s_reg.tno_max <= rhb_pkg::RST_TNO_MAX;
         s_reg.lp_level <= rhb_pkg::RST_LP_LEVEL;
         s_reg.min_swing <= rhb_pkg::RST_MIN_SWING;
         s_reg.lp_boost <= rhb_pkg::RST_LP_BOOST;
         s_reg.burst_tgt <= rhb_pkg::RST_BURST_TGT;
         s_reg.entry_dly <= rhb_pkg::RST_ENTRY_DLY;
         s_reg.exit_dly <= rhb_pkg::RST_EXIT_DLY;
         s_reg.lp_hold <= rhb_pkg::RST_LP_HOLD;
         s_reg.stop_thr <= rhb_pkg::RST_STOP_THR;
      end else begin
         s_reg <= s_next;
      end
   end

   // Zero-wait slave; misaligned or out-of-map addresses flag an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = s_reg.rdata;
   assign low_side_gate = s_reg.ls;
   assign high_side_gate = s_reg.hs;
   assign cap_swing_level = s_reg.swing;
   assign mode_state = s_reg.mode;
endmodule

/* File: verification/rhb_mode_ctrl_props.sv */
// Checker of gate sequencing at the mode controller ports
`timescale 1ns/1ps
module rhb_mode_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ocp_detect,
   input wire logic cap_above_high,
   input wire logic low_side_gate,
   input wire logic high_side_gate,
   input wire logic [1:0] mode_state
);
   logic [15:0] ls_len;
   logic [15:0] hs_len;
   logic [15:0] off_len;
   logic seen_ls;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Run length of each gate state; 16 bits so a burst idle never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_len <= '0;
         hs_len <= '0;
         off_len <= '0;
         seen_ls <= 1'b0;
      end else begin
         ls_len <= low_side_gate ? ls_len + 16'h1 : '0;
         hs_len <= high_side_gate ? hs_len + 16'h1 : '0;
         off_len <= (low_side_gate || high_side_gate) ? '0 : off_len + 16'h1;
         seen_ls <= seen_ls || low_side_gate;
      end
   end
   // Late overcurrent on the low side or cap high level on the high side must end that side
   sequence s_ocp_late;
      ocp_detect && low_side_gate && ls_len >= 16'd45;
   endsequence
   sequence s_cap_high_late;
      cap_above_high && high_side_gate && hs_len >= 16'd45;
   endsequence
   property p_no_overlap;
      !(low_side_gate && high_side_gate);
   endproperty
   property p_ls_first;
      $rose(high_side_gate) |-> seen_ls;
   endproperty
   property p_ls_min;
      $fell(low_side_gate) |-> ls_len >= 16'd40;
   endproperty
   property p_ls_max;
      ls_len <= 16'd1010;
   endproperty
   property p_dt_min;
      ($rose(low_side_gate) && seen_ls) || $rose(high_side_gate)
         |-> off_len >= 16'd8;
   endproperty
   property p_hs_min;
      $fell(high_side_gate) |-> hs_len >= 16'd40;
   endproperty
   property p_dt_max;
      seen_ls && mode_state == 2'h0 |-> off_len <= 16'd100;
   endproperty
   property p_ocp_end;
      s_ocp_late |-> ##[1:4] !low_side_gate;
   endproperty
   property p_hs_end;
      s_cap_high_late |-> ##[1:4] !high_side_gate;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
   a_ls_first: assert property (p_ls_first) else $error("high side first");
   a_ls_min: assert property (p_ls_min) else $error("low side too short");
   a_ls_max: assert property (p_ls_max) else $error("low side too long");
   a_dt_min: assert property (p_dt_min) else $error("dead time short");
   a_hs_min: assert property (p_hs_min) else $error("high side too short");
   a_dt_max: assert property (p_dt_max) else $error("dead time long");
   a_ocp_end: assert property (p_ocp_end) else $error("ocp ignored");
   a_hs_end: assert property (p_hs_end) else $error("cap high ignored");
endmodule
bind rhb_mode_ctrl rhb_mode_ctrl_props chk_props (.pclk(pclk),
   .presetn(presetn), .ocp_detect(ocp_detect), .cap_above_high(cap_above_high),
   .low_side_gate(low_side_gate), .high_side_gate(high_side_gate),
   .mode_state(mode_state));

/* File: verification/rhb_stage_model.sv */
// Behavioural half-bridge power stage answering the gate drives
`timescale 1ns/1ps
module rhb_stage_model #(
   parameter int ON_CYC = 60,
   parameter int PEAK_CYC = 12
) (
   input wire logic pclk,
   input wire logic low_side_gate,
   input wire logic high_side_gate,
   output logic cap_below_low,
   output logic cap_above_high,
   output logic hb_peak,
   output logic ires_le_zero,
   output logic ires_ge_zero
);
   int cnt = 0;
   logic last_ls = 1'b0;
   logic [1:0] gates_q = 2'b00;
   logic dead;
   // Cycles in the present gate state and the side that last conducted
   always @(posedge pclk) begin
      gates_q <= {high_side_gate, low_side_gate};
      cnt <= ({high_side_gate, low_side_gate} != gates_q) ? 0 : cnt + 1;
      if (low_side_gate) last_ls <= 1'b1;
      else if (high_side_gate) last_ls <= 1'b0;
   end
   // Current reverses a few cycles into dead time, before the node peaks
   assign dead = !low_side_gate && !high_side_gate;
   assign cap_below_low = low_side_gate && cnt >= ON_CYC;
   assign cap_above_high = high_side_gate && cnt >= ON_CYC;
   assign hb_peak = dead && cnt >= PEAK_CYC;
   assign ires_le_zero = dead && last_ls && cnt >= 4;
   assign ires_ge_zero = dead && !last_ls && cnt >= 4;
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the resonant half-bridge mode controller
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ocp_detect = 1'b0;
   logic [7:0] power_demand = 8'h50;
   logic [7:0] feedback_ua = 8'h50;
   logic [31:0] prdata;
   logic pready, pslverr, cap_below_low, cap_above_high, hb_peak;
   logic ires_le_zero, ires_ge_zero, low_side_gate, high_side_gate;
   logic [7:0] cap_swing_level;
   logic [1:0] mode_state;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int checks = 0;
   rhb_mode_ctrl i_rhb_mode_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cap_below_low(cap_below_low), .cap_above_high(cap_above_high),
      .ocp_detect(ocp_detect), .cap_mode_near(1'b0), .hb_peak(hb_peak),
      .ires_le_zero(ires_le_zero), .ires_ge_zero(ires_ge_zero),
      .out_rising(1'b0), .power_demand(power_demand),
      .feedback_ua(feedback_ua), .low_side_gate(low_side_gate),
      .high_side_gate(high_side_gate), .cap_swing_level(cap_swing_level),
      .mode_state(mode_state));
   rhb_stage_model i_rhb_stage_model (.pclk(pclk),
      .low_side_gate(low_side_gate), .high_side_gate(high_side_gate),
      .cap_below_low(cap_below_low), .cap_above_high(cap_above_high),
      .hb_peak(hb_peak), .ires_le_zero(ires_le_zero),
      .ires_ge_zero(ires_ge_zero));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // A used-up wait counts as a mismatch and ends the run
   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         fails++;
         $display("[ERR] wait expected below %0d seen %0d", lim, n);
         close_out();
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb answer", 1, n < 20);
      if (n >= 20) close_out();
   endtask
   // Bounded waits, sampled at the falling edge where outputs are settled
   task automatic wait_swing(input logic [7:0] exp, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (cap_swing_level !== exp && n < lim);
      chk("swing", {24'h0, exp}, {24'h0, cap_swing_level});
      if (cap_swing_level !== exp) close_out();
      @(posedge pclk);
   endtask
   task automatic wait_mode(input logic [1:0] m, input int lim);
      int n;
      n = 0;
      while (mode_state !== m && n < lim) begin
         @(negedge pclk);
         n++;
      end
      chk("mode", {30'h0, m}, {30'h0, mode_state});
      if (n >= lim) close_out();
      @(posedge pclk);
   endtask
   task automatic t_regs();
      xfer(1'b0, rhb_pkg::OFS_TON_MIN, 32'h0);
      chk("ton_min reset", 32'h28, rd);
      xfer(1'b0, 8'h38, 32'h0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 32'h0, rd);
      $display("registers done");
   endtask
   task automatic t_hp();
      int n;
      logic ls_seen;
      xfer(1'b1, rhb_pkg::OFS_CTRL, 32'h1);
      n = 0;
      ls_seen = 1'b0;
      while (high_side_gate !== 1'b1 && n < 400) begin
         @(negedge pclk);
         ls_seen |= (low_side_gate === 1'b1);
         n++;
      end
      chk("low side first", 1, ls_seen);
      limit(n, 400);
      n = 0;
      while (low_side_gate !== 1'b1 && n < 400) begin
         @(negedge pclk);
         n++;
      end
      chk("low side after high side", 1, low_side_gate);
      limit(n, 400);
      wait_swing(8'h50, 10);
      wait_mode(2'h0, 1);
      $display("high power done");
   endtask
   task automatic t_ocp();
      int n;
      n = 0;
      while (low_side_gate !== 1'b0 && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      while (low_side_gate !== 1'b1 && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      limit(n, 2000);
      repeat (46) @(posedge pclk);
      ocp_detect <= 1'b1;
      @(posedge pclk);
      ocp_detect <= 1'b0;
      n = 0;
      while (low_side_gate === 1'b1 && n < 8) begin
         @(negedge pclk);
         n++;
      end
      chk("ocp ends low side", 1, n < 6);
      $display("overcurrent done");
   endtask
   task automatic t_lp();
      @(posedge pclk);
      power_demand <= 8'h20;
      wait_mode(2'h1, 3000);
      wait_swing(8'h40, 20);
      power_demand <= 8'h18;
      wait_swing(8'h38, 20);
      feedback_ua <= 8'h1e;
      wait_swing(8'h48, 10);
      repeat (600) @(posedge pclk);
      chk("offset rises", 1, cap_swing_level > 8'h48);
      feedback_ua <= 8'h50;
      $display("low power done");
   endtask
   task automatic t_burst();
      int n;
      int off;
      xfer(1'b1, rhb_pkg::OFS_LP_BOOST, 32'h0);
      power_demand <= 8'h08;
      wait_mode(2'h2, 5000);
      // Optocurrent above burst start keeps the both-off hold going
      feedback_ua <= 8'h78;
      n = 0;
      off = 0;
      while (off < 300 && n < 2000) begin
         @(negedge pclk);
         off = (low_side_gate || high_side_gate) ? 0 : off + 1;
         n++;
      end
      limit(n, 2000);
      @(posedge pclk);
      feedback_ua <= 8'h50;
      n = 0;
      while (low_side_gate !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      chk("burst restart", 1, low_side_gate);
      xfer(1'b0, rhb_pkg::OFS_STATUS, 32'h0);
      chk("burst count", 32'h2, {24'h0, rd[23:16]});
      $display("burst done");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_hp();
      t_ocp();
      t_lp();
      t_burst();
      close_out();
   end
endmodule
